// file: rtcic_params.svh
/*
  Register indices, field positions, reset values and divider counts
  for the interval interrupt and trim logic of the real-time clock.
  Assumes it is included by bare name by every file that needs a constant.
*/
`ifndef RTCIC_PARAMS_SVH
`define RTCIC_PARAMS_SVH

// Register indices; each register is at byte address four times its index.
`define RTCIC_CTRL_IDX      8'h20
`define RTCIC_TRIM_IDX      8'h21
`define RTCIC_ISTAT_IDX     8'h22
`define RTCIC_IMASK_IDX     8'h23
`define RTCIC_PORT_IDX      8'h24

// Control register fields.
`define RTCIC_LONG_BIT      7
`define RTCIC_TESTB_BIT     6
`define RTCIC_TESTA_BIT     5
`define RTCIC_HROE_BIT      4
`define RTCIC_RUN_BIT       3
`define RTCIC_ITS_BIT       2
`define RTCIC_FLAG_BIT      1
`define RTCIC_IEN_BIT       0

// Reset values.
`define RTCIC_CTRL_RESET    8'h00
`define RTCIC_TRIM_RESET    8'h00

// Divider chain terminal counts, in ticks of the stage below.
`define RTCIC_STAGE512_LAST 9'h1FF
`define RTCIC_SEC_LAST      6'h1F
`define RTCIC_SEC15_LAST    6'h2F
`define RTCIC_MIN_LAST      11'h77F

`endif

// file: rtcic_pkg.sv
/*
  Types shared by the real-time clock interval and trim logic.
  Assumes nothing of its surroundings.
*/
package rtcic_pkg;

  typedef logic [7:0] rtcic_byte_t;

  typedef enum logic [1:0] {
    INTV_MINUTE = 2'b00,
    INTV_SECOND = 2'b01,
    INTV_SEC15  = 2'b10
  } rtcic_intv_t;

  typedef enum logic {
    APB_IDLE = 1'b0,
    APB_ACK  = 1'b1
  } rtcic_apb_t;

endpackage : rtcic_pkg

// file: rtcic_mod_counter.sv
/*
  Modulo counter used for each stage of the divider chain.
  Assumes step is a one-cycle pulse and clr has priority over step.
*/
`timescale 1ns/100ps
module rtcic_mod_counter
  import rtcic_pkg::*;
#(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  // Control
  input  wire logic         clr,
  input  wire logic         step,
  input  wire logic [W-1:0] last,
  // Result
  output logic      [W-1:0] count,
  output logic              wrap
);

  typedef struct packed {
    logic [W-1:0] count;
  } rtcic_cnt_t;

  rtcic_cnt_t s_q;
  rtcic_cnt_t s_d;

  // Wrapping at or above the last value lets the modulus shrink while running.
  assign wrap  = step & (s_q.count >= last);
  assign count = s_q.count;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.count = '0;
    end else if (step) begin
      s_d.count = wrap ? '0 : s_q.count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule : rtcic_mod_counter

// file: rtcic_port_pin.sv
/*
  Shared port line that can carry the half-rate clock instead of the port flip-flop.
  Assumes pinIn is synchronous to clk; the wire level is resolved outside from pinOe.
*/
`timescale 1ns/100ps
module rtcic_port_pin
  import rtcic_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // Port access
  input  wire logic portWrite,
  input  wire logic portData,
  output logic      portFf,
  output logic      pinLevel,
  // Clock routing
  input  wire logic clkOutEn,
  input  wire logic halfRateClk,
  // Pin
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe
);

  typedef struct packed {
    logic portFf;
    logic level;
    logic out;
    logic oe;
  } rtcic_pin_t;

  rtcic_pin_t s_q;
  rtcic_pin_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.level = pinIn;
    if (portWrite) begin
      s_d.portFf = portData;
    end
    if (clkOutEn) begin
      s_d.out = halfRateClk;
      s_d.oe  = 1'b1;
    end else begin
      // Quasi-bidirectional line: driven low, released high to the pull-up.
      s_d.out = s_d.portFf;
      s_d.oe  = ~s_d.portFf;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '{portFf: 1'b1, level: 1'b0, out: 1'b1, oe: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign portFf   = s_q.portFf;
  assign pinLevel = s_q.level;
  assign pinOut   = s_q.out;
  assign pinOe    = s_q.oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_port_write_kept: assert property (
    (ce && portWrite) |=> (portFf == $past(portData)))
    else $error("port flip-flop lost a write");

endmodule : rtcic_port_pin

// file: rtcic_interval_irq.sv
/*
  Interval interrupt, trim and clock-output control of the real-time clock, with an APB slave.
  Assumes oscTick is a one-cycle pulse per 32 kHz oscillator period, synchronous to clk.
*/
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "rtcic_params.svh"
module rtcic_interval_irq
  import rtcic_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator cell
  input  wire logic        oscTick,
  output logic             oscRun,
  // Shared port clock pin
  input  wire logic        pinIn,
  output logic             pinOut,
  output logic             pinOe,
  // Interrupts
  input  wire logic        extIntPin,
  output logic             wakeRequest,
  output logic             irq
);

  typedef struct packed {
    rtcic_apb_t  apb;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    rtcic_byte_t ctrl;
    rtcic_byte_t trim;
    logic        irqStat;
    logic        irqMask;
    logic        half;
    logic        adjPend;
    logic        oscRun;
    logic        wake;
    logic        irq;
  } rtcic_state_t;

  rtcic_state_t s_q;
  rtcic_state_t s_d;

  logic        run;
  logic        fall16;
  logic        adjHit;
  logic [8:0]  divCount;
  logic        divWrap;
  logic [5:0]  secCount;
  logic [5:0]  secLast;
  logic        secWrap;
  logic [10:0] minCount;
  logic        minWrap;
  logic        tickEvt;
  rtcic_intv_t mode;
  logic [7:0]  regIdx;
  logic        mapped;
  logic        wrDone;
  logic        portFf;
  logic        pinLevel;

  // Divider chain: 32 kHz ticks, 16 kHz half-rate clock, 512 stage, seconds and minute.
  assign run    = s_q.ctrl[`RTCIC_RUN_BIT];
  assign fall16 = run & oscTick & s_q.half;
  // Resetting the 512 stage as it reaches the trim value repeats that many 16 kHz clocks.
  assign adjHit = fall16 & s_q.adjPend & (s_q.trim != 8'h00)
                & ((divCount + 9'h001) == {1'b0, s_q.trim});
  assign secLast = s_q.ctrl[`RTCIC_LONG_BIT] ? `RTCIC_SEC15_LAST : `RTCIC_SEC_LAST;

  rtcic_mod_counter #(.W(9)) u_stage512 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (~run | adjHit),
    .step    (fall16),
    .last    (`RTCIC_STAGE512_LAST),
    .count   (divCount),
    .wrap    (divWrap)
  );

  rtcic_mod_counter #(.W(6)) u_seconds (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (~run | minWrap),
    .step    (divWrap),
    .last    (secLast),
    .count   (secCount),
    .wrap    (secWrap)
  );

  rtcic_mod_counter #(.W(11)) u_minute (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (~run),
    .step    (divWrap),
    .last    (`RTCIC_MIN_LAST),
    .count   (minCount),
    .wrap    (minWrap)
  );

  always_comb begin
    mode = INTV_MINUTE;
    if (s_q.ctrl[`RTCIC_ITS_BIT]) begin
      mode = s_q.ctrl[`RTCIC_LONG_BIT] ? INTV_SEC15 : INTV_SECOND;
    end
  end

  always_comb begin
    case (mode)
      INTV_SECOND: tickEvt = secWrap;
      INTV_SEC15:  tickEvt = secWrap;
      INTV_MINUTE: tickEvt = minWrap;
      default:     tickEvt = minWrap;
    endcase
  end

  // Register decode; a write takes effect at the edge where pready is seen high.
  assign regIdx = paddr[9:2];
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                && (regIdx >= `RTCIC_CTRL_IDX) && (regIdx <= `RTCIC_PORT_IDX);
  assign wrDone = psel & penable & pwrite & pstrb[0] & mapped & (s_q.apb == APB_ACK);

  function automatic logic [7:0] readMux(input logic [7:0] idx, input rtcic_state_t s,
                                         input logic ff, input logic lvl);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `RTCIC_CTRL_IDX:  v = s.ctrl;
      `RTCIC_TRIM_IDX:  v = s.trim;
      `RTCIC_ISTAT_IDX: v = {7'h00, s.irqStat};
      `RTCIC_IMASK_IDX: v = {7'h00, s.irqMask};
      `RTCIC_PORT_IDX:  v = {6'h00, lvl, ff};
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : readMux

  always_comb begin
    s_d = s_q;
    // APB: one wait cycle, then a single ready cycle.
    case (s_q.apb)
      APB_IDLE: begin
        if (psel && penable) begin
          s_d.apb    = APB_ACK;
          s_d.ready  = 1'b1;
          s_d.slverr = ~mapped;
          s_d.rdata  = {24'h000000, readMux(regIdx, s_q, portFf, pinLevel)};
        end
      end
      APB_ACK: begin
        s_d.apb    = APB_IDLE;
        s_d.ready  = 1'b0;
        s_d.slverr = 1'b0;
      end
      default: begin
        s_d.apb   = APB_IDLE;
        s_d.ready = 1'b0;
      end
    endcase
    if (wrDone && regIdx == `RTCIC_CTRL_IDX) begin
      // Test bits are stored as written and drive nothing.
      s_d.ctrl = pwdata[7:0];
    end
    s_d.ctrl[`RTCIC_FLAG_BIT] = s_d.ctrl[`RTCIC_FLAG_BIT] | tickEvt;
    if (wrDone && regIdx == `RTCIC_TRIM_IDX) begin
      s_d.trim = pwdata[7:0];
    end
    if (wrDone && regIdx == `RTCIC_IMASK_IDX) begin
      s_d.irqMask = pwdata[0];
    end
    s_d.irqStat = (s_q.irqStat & ~(wrDone && regIdx == `RTCIC_ISTAT_IDX && pwdata[0]))
                | tickEvt;
    // Half-rate clock toggles on every oscillator tick and is held low while stopped.
    s_d.half = run & (s_q.half ^ oscTick);
    if (!run || minWrap) begin
      s_d.adjPend = 1'b1;
    end else if (adjHit) begin
      s_d.adjPend = 1'b0;
    end
    s_d.oscRun = s_d.ctrl[`RTCIC_RUN_BIT];
    s_d.wake   = (s_d.ctrl[`RTCIC_FLAG_BIT] & s_d.ctrl[`RTCIC_IEN_BIT]) | extIntPin;
    s_d.irq    = s_d.irqStat & s_d.irqMask;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  rtcic_port_pin u_pin (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .portWrite   (wrDone && regIdx == `RTCIC_PORT_IDX),
    .portData    (pwdata[0]),
    .portFf      (portFf),
    .pinLevel    (pinLevel),
    .clkOutEn    (s_q.ctrl[`RTCIC_HROE_BIT]),
    .halfRateClk (s_q.half),
    .pinIn       (pinIn),
    .pinOut      (pinOut),
    .pinOe       (pinOe)
  );

  assign prdata      = s_q.rdata;
  assign pready      = s_q.ready;
  assign pslverr     = s_q.slverr;
  assign oscRun      = s_q.oscRun;
  assign wakeRequest = s_q.wake;
  assign irq         = s_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_minute_tick_flag: assert property (
    (ce && run && !s_q.ctrl[`RTCIC_ITS_BIT] && minWrap) |=> s_q.ctrl[`RTCIC_FLAG_BIT])
    else $error("minute wrap did not set the tick flag");

  chk_second_tick_count: assert property (
    (ce && tickEvt && s_q.ctrl[`RTCIC_ITS_BIT] && !s_q.ctrl[`RTCIC_LONG_BIT])
      |-> (secCount >= 6'h1F))
    else $error("one second tick came early");

  chk_long_tick_count: assert property (
    (ce && tickEvt && s_q.ctrl[`RTCIC_ITS_BIT] && s_q.ctrl[`RTCIC_LONG_BIT])
      |-> (secCount >= 6'h2F))
    else $error("1.5 second tick came early");

  chk_stop_holds_chain: assert property (
    (ce && !run) |=> (divCount == 9'h000 && !s_q.half && oscRun == run && !tickEvt))
    else $error("divider chain running while stopped");

  chk_set_beats_clear: assert property (
    (ce && tickEvt) |=> (s_q.ctrl[`RTCIC_FLAG_BIT] && s_q.irqStat))
    else $error("tick event lost against a clear");

  chk_request_gated: assert property (
    (ce && !s_d.ctrl[`RTCIC_IEN_BIT] && !extIntPin) |=> !wakeRequest)
    else $error("tick request passed while disabled");

  chk_ext_wake_or: assert property (
    (ce && extIntPin) |=> wakeRequest)
    else $error("external interrupt not ORed into wake request");

  chk_trim_adjust_once: assert property (
    (ce && adjHit) |=> (divCount == 9'h000 && !s_q.adjPend) ##1 !adjHit)
    else $error("trim adjustment misapplied");

  chk_trim_zero_none: assert property (
    (s_q.trim == 8'h00) |-> !adjHit)
    else $error("correction applied with zero trim");

  chk_trim_write_kept: assert property (
    (ce && wrDone && regIdx == `RTCIC_TRIM_IDX) |=> (s_q.trim == $past(pwdata[7:0])))
    else $error("trim write lost");

  chk_reset_clears: assert property (disable iff (1'b0)
    sys_rst |=> (s_q.ctrl == `RTCIC_CTRL_RESET && s_q.trim == `RTCIC_TRIM_RESET))
    else $error("registers not cleared by reset");

  chk_clock_on_pin: assert property (
    (ce && s_q.ctrl[`RTCIC_HROE_BIT]) |=> (pinOe && pinOut == $past(s_q.half)))
    else $error("half-rate clock not on shared pin");

  cov_long_tick:   cover property (ce && tickEvt && mode == INTV_SEC15);
  cov_trim_adjust: cover property (ce && adjHit);
  cov_irq_raised:  cover property (ce && !irq ##1 irq);
  cov_wr_cleared:  cover property (ce && wrDone && !pwdata[`RTCIC_FLAG_BIT] && tickEvt);

endmodule : rtcic_interval_irq

// file: rtcic_core_model.sv
/*
  Behavioural model of the core that reaches the clock registers over APB.
  Assumes a free-running clk and that callers wait out reset before the first transfer.
*/
`timescale 1ns/100ps
`include "rtcic_params.svh"
module rtcic_core_model (
  // Clock
  input  wire logic        clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  // The request is held until pready is sampled high; only the bench watchdog ends a wait.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] val,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h000000, (idx == `RTCIC_CTRL_IDX) ? (val & 8'h9F) : val};
    pstrb   <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rtcic_core_model

// file: rtcic_interval_irq_tb.sv
/*
  Self-checking testbench of the interval interrupt, trim and clock-output logic.
  Assumes the oscillator pulse may be held high so that every clock is one 32 kHz period.
*/
`timescale 1ns/100ps
`include "rtcic_params.svh"
module rtcic_interval_irq_tb;
  import rtcic_pkg::*;
  logic        clk;
  logic        sysRst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        oscRun;
  logic        extIntPin;
  logic        pinOut;
  logic        pinOe;
  logic        wakeRequest;
  logic        irq;
  wire logic   pinIn;
  logic [31:0] v;
  logic        e;
  int          nMismatch;
  int          numChecks;
  int          n;
  int          c;
  logic        p;

  // The shared line has a pull-up, so it reads high whenever nobody drives it.
  assign pinIn = pinOe ? pinOut : 1'b1;

  rtcic_core_model u_core (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  rtcic_interval_irq u_dut (.clk(clk), .sys_rst(sysRst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscTick(1'b1), .oscRun(oscRun),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .extIntPin(extIntPin),
    .wakeRequest(wakeRequest), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic [31:0] d;
    logic        er;
    u_core.xfer(1'b1, idx, val, d, er);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic er);
    u_core.xfer(1'b0, idx, 8'h00, d, er);
  endtask : rd

  // Restarting the chain from a stopped state also arms the trim adjustment.
  task automatic run_tick(input logic [7:0] cv, input logic [7:0] tv, input int lim,
                          output int cnt);
    wr(`RTCIC_TRIM_IDX, tv);
    wr(`RTCIC_CTRL_IDX, 8'h00);
    wr(`RTCIC_CTRL_IDX, cv);
    cnt = 0;
    while (wakeRequest !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      cnt++;
    end
  endtask : run_tick

  task automatic complete_run;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (140000) @(posedge clk);
    nMismatch++;
    complete_run();
  end

  initial begin
    sysRst = 1'b1;
    extIntPin = 1'b0;
    nMismatch = 0;
    numChecks = 0;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    rd(`RTCIC_CTRL_IDX, v, e);
    chk("ctrl reset", v, 32'h00000000);
    rd(`RTCIC_TRIM_IDX, v, e);
    chk("trim reset", v, 32'h00000000);
    wr(`RTCIC_TRIM_IDX, 8'hA5);
    rd(`RTCIC_TRIM_IDX, v, e);
    chk("trim rw", v, 32'h000000A5);
    rd(8'h30, v, e);
    chk("unmapped err", {31'h0, e}, 32'h00000001);
    $display("test registers done");
    wr(`RTCIC_CTRL_IDX, 8'h63);
    rd(`RTCIC_CTRL_IDX, v, e);
    chk("flag by write", v, 32'h00000003);
    repeat (2) @(posedge clk);
    chk("wake enabled", {31'h0, wakeRequest}, 32'h00000001);
    wr(`RTCIC_CTRL_IDX, 8'h02);
    repeat (2) @(posedge clk);
    chk("wake blocked", {31'h0, wakeRequest}, 32'h00000000);
    extIntPin <= 1'b1;
    repeat (3) @(posedge clk);
    chk("wake ext", {31'h0, wakeRequest}, 32'h00000001);
    extIntPin <= 1'b0;
    wr(`RTCIC_CTRL_IDX, 8'h00);
    rd(`RTCIC_CTRL_IDX, v, e);
    chk("flag cleared", v, 32'h00000000);
    $display("test flag done");
    wr(`RTCIC_PORT_IDX, 8'h00);
    rd(`RTCIC_PORT_IDX, v, e);
    chk("port line", v, 32'h00000000);
    wr(`RTCIC_CTRL_IDX, 8'h18);
    wr(`RTCIC_PORT_IDX, 8'h01);
    rd(`RTCIC_PORT_IDX, v, e);
    chk("port ff", {31'h0, v[0]}, 32'h00000001);
    chk("osc run", {31'h0, oscRun}, 32'h00000001);
    chk("clock oe", {31'h0, pinOe}, 32'h00000001);
    c = 0;
    p = pinOut;
    repeat (8) begin
      @(posedge clk);
      if (pinOut !== p) c++;
      p = pinOut;
    end
    chk("clock toggles", 32'(c), 32'h00000008);
    wr(`RTCIC_CTRL_IDX, 8'h00);
    repeat (2) @(posedge clk);
    chk("osc stop", {31'h0, oscRun}, 32'h00000000);
    chk("port oe", {31'h0, pinOe}, 32'h00000000);
    $display("test pin done");
    wr(`RTCIC_IMASK_IDX, 8'h01);
    run_tick(8'h8D, 8'h40, 49400, n);
    chk("long tick", {31'h0, n >= 49276 && n <= 49292}, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("irq set", {31'h0, irq}, 32'h00000001);
    rd(`RTCIC_CTRL_IDX, v, e);
    chk("hw flag", {31'h0, v[1]}, 32'h00000001);
    wr(`RTCIC_ISTAT_IDX, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq clear", {31'h0, irq}, 32'h00000000);
    $display("test long interval done");
    wr(`RTCIC_IMASK_IDX, 8'h00);
    run_tick(8'h0D, 8'h00, 32900, n);
    chk("second tick", {31'h0, n >= 32764 && n <= 32780}, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h00000000);
    $display("test second done");
    run_tick(8'h09, 8'h00, 32900, n);
    chk("minute mode", 32'(n), 32'(32900));
    $display("test minute done");
    complete_run();
  end
endmodule : rtcic_interval_irq_tb
